// ==== pkg/irpw_pkg.sv ====
/*
 * Shared definitions for the pulse-width infrared remote codec: frame
 * timing, carrier rate, field widths, state codes and the request carrier.
 * Assumes a single system clock whose rate is given by IRPW_CLK_HZ.
 */
package irpw_pkg;

  localparam int unsigned IRPW_CLK_HZ = 10_000_000;
  localparam int unsigned IRPW_CARRIER_HZ = 38_000;
  localparam int unsigned IRPW_START_US = 2400;
  localparam int unsigned IRPW_ONE_US = 1200;
  localparam int unsigned IRPW_ZERO_US = 600;
  localparam int unsigned IRPW_GAP_US = 600;

  localparam int unsigned IRPW_START_CYC = IRPW_START_US * (IRPW_CLK_HZ / 1_000_000);
  localparam int unsigned IRPW_ONE_CYC = IRPW_ONE_US * (IRPW_CLK_HZ / 1_000_000);
  localparam int unsigned IRPW_ZERO_CYC = IRPW_ZERO_US * (IRPW_CLK_HZ / 1_000_000);
  localparam int unsigned IRPW_GAP_CYC = IRPW_GAP_US * (IRPW_CLK_HZ / 1_000_000);
  // Half a carrier period, rounded down.
  localparam int unsigned IRPW_HALF_CAR_CYC = IRPW_CLK_HZ / (2 * IRPW_CARRIER_HZ);

  // Receive tolerance: a width is accepted from 3/4 to 5/4 of its nominal value.
  localparam int unsigned IRPW_TOL_NUM_LO = 3;
  localparam int unsigned IRPW_TOL_NUM_HI = 5;
  localparam int unsigned IRPW_TOL_DEN = 4;

  localparam int unsigned IRPW_CMD_W = 7;
  localparam int unsigned IRPW_DEV_W = 5;
  localparam int unsigned IRPW_FRAME_BITS = IRPW_CMD_W + IRPW_DEV_W;
  localparam int unsigned IRPW_CNT_W = 16;
  localparam int unsigned IRPW_FIFO_DEPTH = 32;
  localparam logic [IRPW_DEV_W-1:0] IRPW_PEER_DEVICE = 5'h01;

  typedef struct packed {
    logic [IRPW_DEV_W-1:0] device;
    logic [IRPW_CMD_W-1:0] command;
  } irpw_tx_req_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_MARK = 3'b010,
    TX_GAP = 3'b100
  } irpw_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_WAIT = 3'b010,
    RX_BITS = 3'b100
  } irpw_rx_state_t;

  // Button code to legacy value; zero marks a code that legacy mode ignores.
  function automatic logic [7:0] irpw_legacy_map(input logic [IRPW_CMD_W-1:0] code);
    case (code)
      7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08:
        irpw_legacy_map = {1'b0, code} + 8'h01;
      7'h09: irpw_legacy_map = 8'h0B;
      7'h10: irpw_legacy_map = 8'h0A;
      7'h11: irpw_legacy_map = 8'h0D;
      7'h12: irpw_legacy_map = 8'h0C;
      7'h0C: irpw_legacy_map = 8'h0E;
      7'h13: irpw_legacy_map = 8'h0F;
      7'h14: irpw_legacy_map = 8'h10;
      7'h15: irpw_legacy_map = 8'h11;
      default: irpw_legacy_map = 8'h00;
    endcase
  endfunction

endpackage

// ==== core/irpw_fifo.sv ====
/*
 * Flip-flop FIFO with valid/ready on both sides and registered flags.
 * Assumes DEPTH is a power of two so the pointers wrap naturally.
 */
`timescale 1ns/1ps
`default_nettype none
module irpw_fifo
  import irpw_pkg::*;
#(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sValid,
  output logic sReady,
  input wire logic [WIDTH-1:0] sData,
  output logic mValid,
  input wire logic mReady,
  output logic [WIDTH-1:0] mData
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = sValid && sReady;
  assign pop = mValid && mReady;
  assign mData = mem[rdPtr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + (AW+1)'(1);
    end else if (pop && !push) begin
      next_count = count - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= sData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      sReady <= 1'b0;
      mValid <= 1'b0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + AW'(1);
      end
      if (pop) begin
        rdPtr <= rdPtr + AW'(1);
      end
      count <= next_count;
      sReady <= next_count != (AW+1)'(DEPTH);
      mValid <= next_count != '0;
    end
  end
endmodule
`default_nettype wire

// ==== core/irpw_codec.sv ====
/*
 * Pulse-width infrared remote codec: a queued transmitter driving the LED
 * with a modulated carrier, and a blocking receiver with legacy and full modes.
 * Assumes demodulated receiver inputs that sit high in silence and go low
 * during a carrier burst, and requesters that drop no request while ready is low.
 */
`timescale 1ns/1ps
`default_nettype none
module irpw_codec
  import irpw_pkg::*;
#(
  parameter int unsigned START_CYC = IRPW_START_CYC,
  parameter int unsigned ONE_CYC = IRPW_ONE_CYC,
  parameter int unsigned ZERO_CYC = IRPW_ZERO_CYC,
  parameter int unsigned GAP_CYC = IRPW_GAP_CYC,
  parameter int unsigned HALF_CAR_CYC = IRPW_HALF_CAR_CYC,
  parameter int unsigned FIFO_DEPTH = IRPW_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic txReqValid,
  input wire irpw_tx_req_t txReq,
  output logic txReqReady,
  output logic irLed,
  output logic txBusy,
  output logic txDone,
  input wire logic irIn0,
  input wire logic irIn3,
  input wire logic rxFullMode,
  input wire logic rxStart,
  output logic rxBusy,
  output logic rxDone,
  output logic [7:0] generalByteThirteen
);
  localparam int unsigned CW = IRPW_CNT_W;
  localparam logic [CW-1:0] START_L = CW'(START_CYC);
  localparam logic [CW-1:0] ONE_L = CW'(ONE_CYC);
  localparam logic [CW-1:0] ZERO_L = CW'(ZERO_CYC);
  localparam logic [CW-1:0] GAP_L = CW'(GAP_CYC);
  localparam logic [CW-1:0] HALF_L = CW'(HALF_CAR_CYC);
  localparam logic [CW-1:0] START_LO = CW'(START_CYC * IRPW_TOL_NUM_LO / IRPW_TOL_DEN);
  localparam logic [CW-1:0] START_HI = CW'(START_CYC * IRPW_TOL_NUM_HI / IRPW_TOL_DEN);
  localparam logic [CW-1:0] ONE_LO = CW'(ONE_CYC * IRPW_TOL_NUM_LO / IRPW_TOL_DEN);
  localparam logic [CW-1:0] ONE_HI = CW'(ONE_CYC * IRPW_TOL_NUM_HI / IRPW_TOL_DEN);
  localparam logic [CW-1:0] ZERO_LO = CW'(ZERO_CYC * IRPW_TOL_NUM_LO / IRPW_TOL_DEN);
  localparam logic [CW-1:0] ZERO_HI = CW'(ZERO_CYC * IRPW_TOL_NUM_HI / IRPW_TOL_DEN);
  localparam logic [3:0] LAST_TX_IDX = 4'(IRPW_FRAME_BITS);
  localparam logic [3:0] LAST_RX_IDX = 4'(IRPW_FRAME_BITS - 1);

  // Transmit request queue.
  irpw_tx_req_t fifoData;
  logic fifoValid;
  logic txPop;

  irpw_fifo #(
    .WIDTH(IRPW_FRAME_BITS),
    .DEPTH(FIFO_DEPTH)
  ) reqQueue (
    .clk(clk),
    .rst_n(rst_n),
    .sValid(txReqValid),
    .sReady(txReqReady),
    .sData(txReq),
    .mValid(fifoValid),
    .mReady(txPop),
    .mData(fifoData)
  );

  irpw_tx_state_t txState;
  logic [CW-1:0] txCnt;
  logic [CW-1:0] carCnt;
  logic carrier;
  logic [3:0] txIdx;
  logic [IRPW_FRAME_BITS-1:0] txShift;
  logic [CW-1:0] markCycles;
  logic markEnd;
  logic gapEnd;

  assign txPop = fifoValid && txState == TX_IDLE;
  assign markCycles = (txIdx == '0) ? START_L : (txShift[0] ? ONE_L : ZERO_L);
  assign markEnd = txState == TX_MARK && txCnt == markCycles - CW'(1);
  assign gapEnd = txState == TX_GAP && txCnt == GAP_L - CW'(1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txState <= TX_IDLE;
      txCnt <= '0;
      txIdx <= '0;
      txShift <= '0;
      txDone <= 1'b0;
      txBusy <= 1'b0;
    end else begin
      txDone <= 1'b0;
      txCnt <= txCnt + CW'(1);
      case (txState)
        TX_IDLE: begin
          if (txPop) begin
            // command bits first, then device bits, lsb first
            // seven command bits and five device bits
            // the carrier has no room for commands above 127
            txShift <= {fifoData.device, fifoData.command};
            txIdx <= '0;
            txCnt <= '0;
            txState <= TX_MARK;
            txBusy <= 1'b1;
          end
        end
        TX_MARK: begin
          if (markEnd) begin
            if (txIdx != '0) begin
              txShift <= txShift >> 1;
            end
            txCnt <= '0;
            txState <= TX_GAP;
          end
        end
        TX_GAP: begin
          if (gapEnd) begin
            txCnt <= '0;
            // done only after the final gap
            if (txIdx == LAST_TX_IDX) begin
              txDone <= 1'b1;
              txBusy <= 1'b0;
              txState <= TX_IDLE;
            end else begin
              txIdx <= txIdx + 4'h1;
              txState <= TX_MARK;
            end
          end
        end
        default: begin
          txState <= TX_IDLE;
          txBusy <= 1'b0;
        end
      endcase
    end
  end

  // periods come from the clock rate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carCnt <= '0;
      carrier <= 1'b1;
    end else if (txState != TX_MARK) begin
      carCnt <= '0;
      carrier <= 1'b1;
    end else if (carCnt == HALF_L - CW'(1)) begin
      carCnt <= '0;
      carrier <= !carrier;
    end else begin
      carCnt <= carCnt + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irLed <= 1'b0;
    end else begin
      irLed <= txState == TX_MARK && carrier;
    end
  end

  // Receiver input conditioning; bit 0 is input 0, bit 1 is input 3.
  logic [1:0] syncA;
  logic [1:0] syncB;
  logic [1:0] syncC;
  logic [1:0] filt;
  logic prevLevel;
  logic rxLevel;
  logic rxModeFull;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= 2'h3;
      syncB <= 2'h3;
      syncC <= 2'h3;
      filt <= 2'h3;
    end else begin
      syncA <= {irIn3, irIn0};
      syncB <= syncA;
      syncC <= syncB;
      for (int i = 0; i < 2; i++) begin
        if (syncB[i] == syncC[i]) begin
          filt[i] <= syncC[i];
        end
      end
    end
  end

  // input 0 for legacy, input 3 for full
  assign rxLevel = rxModeFull ? filt[1] : filt[0];

  irpw_rx_state_t rxState;
  logic [CW-1:0] markCnt;
  logic [CW-1:0] spaceCnt;
  logic [3:0] rxIdx;
  logic [IRPW_FRAME_BITS-1:0] rxShift;
  logic pulseEnd;
  logic isStart;
  logic isOne;
  logic isZero;
  logic [IRPW_CMD_W-1:0] rxCmd;
  logic [7:0] legacyVal;

  assign pulseEnd = !prevLevel && rxLevel;
  assign isStart = markCnt >= START_LO && markCnt <= START_HI;
  assign isOne = markCnt >= ONE_LO && markCnt <= ONE_HI;
  assign isZero = markCnt >= ZERO_LO && markCnt <= ZERO_HI;
  assign rxCmd = rxShift[IRPW_CMD_W-1:0];
  assign legacyVal = irpw_legacy_map(rxCmd);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prevLevel <= 1'b1;
      markCnt <= '0;
      spaceCnt <= '0;
    end else begin
      prevLevel <= rxLevel;
      if (!rxLevel) begin
        markCnt <= (prevLevel || markCnt == '1) ? (prevLevel ? CW'(1) : markCnt)
                                                : markCnt + CW'(1);
        spaceCnt <= '0;
      end else if (spaceCnt != '1) begin
        spaceCnt <= spaceCnt + CW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState <= RX_IDLE;
      rxIdx <= '0;
      rxShift <= '0;
      rxBusy <= 1'b0;
      rxDone <= 1'b0;
      rxModeFull <= 1'b0;
      generalByteThirteen <= '0;
    end else begin
      rxDone <= 1'b0;
      case (rxState)
        RX_IDLE: begin
          // arm and block until a new frame
          if (rxStart) begin
            rxModeFull <= rxFullMode;
            rxBusy <= 1'b1;
            rxState <= RX_WAIT;
          end
        end
        RX_WAIT: begin
          if (pulseEnd && isStart) begin
            rxIdx <= '0;
            rxShift <= '0;
            rxState <= RX_BITS;
          end
        end
        RX_BITS: begin
          if (pulseEnd) begin
            if (isStart) begin
              rxIdx <= '0;
              rxShift <= '0;
            end else if (isOne || isZero) begin
              rxShift[rxIdx] <= isOne;
              rxIdx <= rxIdx + 4'h1;
              if (rxIdx == LAST_RX_IDX) begin
                rxState <= RX_WAIT;
                if (rxModeFull) begin
                  generalByteThirteen <= {1'b0, rxCmd};
                  rxDone <= 1'b1;
                  rxBusy <= 1'b0;
                  rxState <= RX_IDLE;
                end else if (legacyVal != '0) begin
                  // unknown codes keep the receiver waiting
                  generalByteThirteen <= legacyVal;
                  rxDone <= 1'b1;
                  rxBusy <= 1'b0;
                  rxState <= RX_IDLE;
                end
              end
            end else begin
              rxState <= RX_WAIT;
            end
          end else if (rxLevel && spaceCnt > START_HI) begin
            rxState <= RX_WAIT;
          end
        end
        default: begin
          rxState <= RX_IDLE;
          rxBusy <= 1'b0;
        end
      endcase
    end
  end

  // Checking logic.
  logic [CW-1:0] markRun;
  logic [CW-1:0] gapRun;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      markRun <= '0;
      gapRun <= '0;
    end else begin
      markRun <= (txState == TX_MARK) ? markRun + CW'(1) : '0;
      gapRun <= (txState == TX_GAP) ? gapRun + CW'(1) : '0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_mark_width: assert property (
    $fell(txState == TX_MARK) |-> markRun == START_L || markRun == ONE_L || markRun == ZERO_L)
    else $error("Transmitted pulse has a wrong width.");
  chk_gap_width: assert property (
    $fell(txState == TX_GAP) |-> gapRun == GAP_L)
    else $error("Silent gap has a wrong width.");
  chk_led_dark_gap: assert property (
    irLed |-> $past(txState) == TX_MARK)
    else $error("LED lit outside a pulse.");
  chk_carrier_half: assert property (
    (txState == TX_MARK && $changed(carrier)) |=> ($stable(carrier) || txState != TX_MARK) [*8])
    else $error("Carrier half period too short.");
  chk_frame_bits: assert property (
    txDone |-> $past(txIdx) == LAST_TX_IDX && $past(txState) == TX_GAP)
    else $error("Frame ended at a wrong bit.");
  chk_start_first: assert property (
    $rose(txState == TX_MARK) && $past(txState) == TX_IDLE |-> markCycles == START_L)
    else $error("Frame did not begin with a start pulse.");
  chk_full_range: assert property (
    rxDone && rxModeFull |-> generalByteThirteen[7] == 1'b0)
    else $error("Full mode value above 127.");
  chk_legacy_range: assert property (
    rxDone && !rxModeFull |-> generalByteThirteen >= 8'h01 && generalByteThirteen <= 8'h11)
    else $error("Legacy value out of 1 to 17.");
  chk_busy_release: assert property (
    rxDone |-> !rxBusy && $past(rxBusy))
    else $error("Result given without a pending receive.");
  chk_bad_drop: assert property (
    rxState == RX_BITS && pulseEnd && !isStart && !isOne && !isZero |=> rxState == RX_WAIT)
    else $error("Bad width did not drop the frame.");

  cov_tx_frame: cover property (txDone);
  cov_rx_full: cover property (rxDone && rxModeFull);
  cov_rx_legacy: cover property (rxDone && !rxModeFull);
  cov_rx_drop: cover property (rxState == RX_BITS ##1 rxState == RX_WAIT);
endmodule
`default_nettype wire

// ==== dv/irpw_remote_model.sv ====
/*
 * Behavioural handheld remote that sends pulse-width coded frames.
 * Assumes the receiver expects a demodulated line that idles high and goes low in a burst.
 */
`timescale 1ns/1ps
`default_nettype none
module irpw_remote_model
  import irpw_pkg::*;
#(
  parameter int unsigned START_CYC = 40,
  parameter int unsigned ONE_CYC = 20,
  parameter int unsigned ZERO_CYC = 10,
  parameter int unsigned GAP_CYC = 10
) (
  input wire logic clk,
  input wire logic send,
  input wire logic pinSel,
  input wire irpw_tx_req_t frame,
  input wire logic [3:0] badBit,
  output logic irIn0,
  output logic irIn3,
  output logic busy
);
  logic line;
  int unsigned width;
  // The input that is not selected stays high, as a quiet demodulator would.
  assign irIn0 = pinSel ? 1'b1 : line;
  assign irIn3 = pinSel ? line : 1'b1;
  task automatic burst(input int unsigned n);
    line = 1'b0;
    repeat (n) @(negedge clk);
    line = 1'b1;
    repeat (GAP_CYC) @(negedge clk);
  endtask
  initial begin
    line = 1'b1;
    busy = 1'b0;
    forever begin
      @(negedge clk);
      if (send) begin
        busy = 1'b1;
        burst(START_CYC);
        for (int i = 0; i < 12; i++) begin
          width = frame[i] ? ONE_CYC : ZERO_CYC;
          if (i == badBit) width = ZERO_CYC * 14 / 10;
          burst(width);
        end
        busy = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/test_ir_pulse_width_remote_codec.sv ====
/*
 * Self-checking bench for the infrared codec: LED frames, queue fill, receive modes.
 * Assumes shortened pulse counts and a remote model on the receive inputs.
 */
`timescale 1ns/1ps
`default_nettype none
module test_ir_pulse_width_remote_codec
  import irpw_pkg::*;
;
  localparam int unsigned ST = 40;
  localparam int unsigned ON = 20;
  localparam int unsigned ZE = 10;
  localparam int unsigned GP = 10;
  localparam int unsigned HC = 9;
  logic clk, rst_n, txReqValid, txReqReady, irLed, txBusy, txDone, irIn0, irIn3;
  logic rxFullMode, rxStart, rxBusy, rxDone, send, pinSel, pBusy;
  logic [7:0] generalByteThirteen;
  logic [3:0] badBit;
  irpw_tx_req_t txReq, frm;
  int n_errors, checks, n;
  logic [6:0] lcode [17] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08,
    7'h10, 7'h09, 7'h12, 7'h11, 7'h0C, 7'h13, 7'h14, 7'h15};
  irpw_codec #(.START_CYC(ST), .ONE_CYC(ON), .ZERO_CYC(ZE), .GAP_CYC(GP), .HALF_CAR_CYC(HC),
    .FIFO_DEPTH(32)) DUT (.clk(clk), .rst_n(rst_n), .txReqValid(txReqValid), .txReq(txReq),
    .txReqReady(txReqReady), .irLed(irLed), .txBusy(txBusy), .txDone(txDone), .irIn0(irIn0),
    .irIn3(irIn3), .rxFullMode(rxFullMode), .rxStart(rxStart), .rxBusy(rxBusy),
    .rxDone(rxDone), .generalByteThirteen(generalByteThirteen));
  irpw_remote_model #(.START_CYC(ST), .ONE_CYC(ON), .ZERO_CYC(ZE), .GAP_CYC(GP)) remote (
    .clk(clk), .send(send), .pinSel(pinSel), .frame(frm), .badBit(badBit), .irIn0(irIn0),
    .irIn3(irIn3), .busy(pBusy));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    close_out();
  end
  task automatic cmp_word(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({11'h000, got}, {11'h000, exp});
  endtask
  // Decodes one LED frame from its carrier envelope and checks widths, gaps and completion.
  task automatic capture_frame(output logic [11:0] bits);
    int w, lowRun, gap, firstHi;
    bit seenLow;
    lowRun = 0;
    for (int p = 0; p < 13; p++) begin
      gap = lowRun;
      while (!irLed && gap < 3000) begin
        @(negedge clk);
        gap++;
      end
      if (p > 0) cmp_bit(gap + 1 >= GP && gap <= GP + HC + 1, 1'b1);
      w = 1;
      lowRun = 0;
      firstHi = 1;
      seenLow = 0;
      while (lowRun <= HC && !txDone) begin
        @(negedge clk);
        if (irLed) begin
          w = w + lowRun + 1;
          lowRun = 0;
          if (!seenLow) firstHi++;
        end else begin
          lowRun++;
          seenLow = 1;
        end
      end
      if (p == 0) begin
        cmp_word(12'(firstHi), 12'(HC));
        cmp_bit(txBusy, 1'b1);
        cmp_bit(w > (ST + ON) / 2, 1'b1);
      end else bits[p-1] = (w > (ZE + ON) / 2);
    end
    while (!txDone && lowRun < GP + 50) begin
      @(negedge clk);
      lowRun++;
    end
    cmp_bit(txDone, 1'b1);
    cmp_bit(lowRun >= GP && irLed === 1'b0, 1'b1);
    cmp_bit(txBusy, 1'b0);
  endtask
  task automatic t_tx_single();
    logic [11:0] b;
    txReq = '{5'h01, 7'h55};
    txReqValid = 1'b1;
    while (!txReqReady) @(negedge clk);
    @(negedge clk);
    txReqValid = 1'b0;
    capture_frame(b);
    cmp_word(b, {5'h01, 7'h55});
    $display("test tx_single done");
  endtask
  task automatic t_tx_fill();
    logic [11:0] b;
    logic tk;
    n = 0;
    txReq = '{5'h01, 7'h00};
    txReqValid = 1'b1;
    fork
      begin
        while (n < 40) begin
          tk = txReqReady;
          @(negedge clk);
          if (!tk) break;
          n++;
          txReq.command = 7'(n);
        end
        txReqValid = 1'b0;
      end
      capture_frame(b);
    join
    cmp_word(b, {5'h01, 7'h00});
    cmp_bit(n >= 32 && n <= 34, 1'b1);
    for (int i = 1; i < n; i++) begin
      capture_frame(b);
      cmp_word(b, {5'h01, 7'(i)});
    end
    $display("test tx_fill done");
  endtask
  task automatic arm(input logic full);
    rxFullMode = full;
    rxStart = 1'b1;
    @(negedge clk);
    rxStart = 1'b0;
  endtask
  task automatic play(input logic pin, input irpw_tx_req_t r, input logic [3:0] bad,
    output logic seen);
    int post;
    // The remote only looks at send between frames, so let it finish first.
    while (pBusy) @(negedge clk);
    pinSel = pin;
    frm = r;
    badBit = bad;
    send <= 1'b1;
    @(negedge clk);
    send <= 1'b0;
    seen = 1'b0;
    post = 0;
    while (!seen && post < 30) begin
      @(negedge clk);
      seen = rxDone;
      if (!pBusy) post++;
    end
  endtask
  task automatic t_rx_legacy();
    logic s;
    for (int i = 0; i < 17; i++) begin
      arm(1'b0);
      play(1'b0, '{5'(i), lcode[i]}, 4'hF, s);
      cmp_bit(s, 1'b1);
      cmp_word({4'h0, generalByteThirteen}, 12'(i + 1));
    end
    cmp_bit(rxBusy, 1'b0);
    $display("test rx_legacy done");
  endtask
  task automatic t_rx_ignore();
    logic s;
    arm(1'b0);
    play(1'b0, '{5'h01, 7'h0A}, 4'hF, s);
    cmp_bit(s, 1'b0);
    cmp_bit(rxBusy, 1'b1);
    play(1'b1, '{5'h01, 7'h01}, 4'hF, s);
    cmp_bit(s, 1'b0);
    play(1'b0, '{5'h01, 7'h15}, 4'hF, s);
    cmp_bit(s, 1'b1);
    cmp_word({4'h0, generalByteThirteen}, 12'h011);
    $display("test rx_ignore done");
  endtask
  task automatic t_rx_full();
    logic s;
    logic [6:0] c [3] = '{7'h00, 7'h7F, 7'h2A};
    for (int i = 0; i < 3; i++) begin
      arm(1'b1);
      play(1'b1, '{5'h01, c[i]}, 4'hF, s);
      cmp_bit(s, 1'b1);
      cmp_word({4'h0, generalByteThirteen}, {5'h00, c[i]});
    end
    arm(1'b1);
    play(1'b0, '{5'h01, 7'h05}, 4'hF, s);
    cmp_bit(s, 1'b0);
    play(1'b1, '{5'h1F, 7'h05}, 4'hF, s);
    cmp_word({3'h0, s, generalByteThirteen}, 12'h105);
    $display("test rx_full done");
  endtask
  task automatic t_rx_bad();
    logic s;
    arm(1'b1);
    play(1'b1, '{5'h01, 7'h33}, 4'h3, s);
    cmp_bit(s, 1'b0);
    play(1'b1, '{5'h01, 7'h33}, 4'hF, s);
    cmp_word({3'h0, s, generalByteThirteen}, 12'h133);
    $display("test rx_bad done");
  endtask
  initial begin
    rst_n = 1'b0;
    txReqValid = 1'b0;
    txReq = '0;
    rxFullMode = 1'b0;
    rxStart = 1'b0;
    send = 1'b0;
    pinSel = 1'b0;
    frm = '0;
    badBit = 4'hF;
    n_errors = 0;
    checks = 0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_tx_single();
    t_tx_fill();
    t_rx_legacy();
    t_rx_ignore();
    t_rx_full();
    t_rx_bad();
    close_out();
  end
endmodule
`default_nettype wire
